// ---- rtl/listen_rc_cal_pkg.sv ----
// Constants, codes and types for the listen and RC calibration registers
package listen_rc_cal_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [6:0] ADDR_OPMODE = 7'h01;
	localparam logic [6:0] ADDR_FRF_LOW = 7'h09;
	localparam logic [6:0] ADDR_RC_CAL = 7'h0A;
	localparam logic [6:0] ADDR_AFC = 7'h0B;
	localparam logic [6:0] ADDR_BAT = 7'h0C;
	localparam logic [6:0] ADDR_WAKE_CFG = 7'h0D;
	localparam logic [6:0] ADDR_IDLE_DUR = 7'h0E;
	localparam logic [6:0] ADDR_RX_DUR = 7'h0F;
	localparam logic [6:0] ADDR_REV = 7'h10;
	// ==========================================================
	// Field positions
	localparam int BIT_WAKE_EN = 6;
	localparam int BIT_WAKE_ABORT = 5;
	localparam int BIT_MODE_LO = 2;
	localparam int BIT_CAL_TRIG = 7;
	localparam int BIT_CAL_DONE = 6;
	localparam int BIT_AFC_LOW = 5;
	localparam int BIT_BAT_LIVE = 4;
	localparam int BIT_BAT_EN = 3;
	localparam int BIT_IDLE_UNIT = 6;
	localparam int BIT_RX_UNIT = 4;
	localparam int BIT_CRITERION = 3;
	localparam int BIT_EXIT = 1;
	// ==========================================================
	// Operating modes and codes
	localparam logic [2:0] MODE_SLEEP = 3'h0;
	localparam logic [2:0] MODE_STANDBY = 3'h1;
	localparam logic [2:0] MODE_SYNTH = 3'h2;
	localparam logic [2:0] MODE_RX = 3'h4;
	localparam logic [1:0] EXIT_STAY_RX = 2'h0;
	localparam logic [1:0] EXIT_TO_MODE = 2'h1;
	localparam logic [1:0] EXIT_RESUME = 2'h2;
	localparam logic [1:0] UNIT_BASE = 2'h1;
	localparam logic [1:0] UNIT_MID = 2'h2;
	localparam logic [1:0] UNIT_LONG = 2'h3;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_FRF_LOW = 8'h00;
	localparam logic [2:0] RST_BAT_TRIM = 3'h2;
	localparam logic [1:0] RST_IDLE_UNIT = 2'h2;
	localparam logic [1:0] RST_RX_UNIT = 2'h1;
	localparam logic [1:0] RST_EXIT = 2'h1;
	localparam logic [7:0] RST_IDLE_COUNT = 8'hF5;
	localparam logic [7:0] RST_RX_COUNT = 8'h20;
	// ==========================================================
	// Timing: 64 us base unit; each larger unit is 64 times the last
	localparam int CLK_MHZ = 200;
	localparam int UNIT_BASE_US = 64;
	localparam int UNIT_BASE_CYC = UNIT_BASE_US * CLK_MHZ;
	localparam logic [5:0] UNIT_RATIO_LAST = 6'h3F;
	localparam int CAL_CYC_DEFAULT = 256;
	typedef enum logic [2:0] {L_OFF, L_IDLE, L_RX, L_HOLD, L_STOPPED} wake_state_e;
endpackage : listen_rc_cal_pkg

// ---- rtl/listen_rc_cal_regs.sv ----
// Listen-mode, RC calibration and battery detector register bank
`timescale 1ns/1ps
`default_nettype none

module listen_rc_cal_regs
	import listen_rc_cal_pkg::*;
#(
	parameter int UNIT_BASE_CYCLES = UNIT_BASE_CYC,
	parameter int CAL_CYCLES = CAL_CYC_DEFAULT,
	parameter logic [3:0] FULL_REV = 4'h1, // Arbitrary value
	parameter logic [3:0] MASK_REV = 4'h0 // Arbitrary value
)(
	input wire logic clock_i, // 200 MHz clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic [6:0] reg_addr_i, // Register address
	input wire logic [7:0] reg_wdata_i, // Write data
	input wire logic reg_wr_i, // Write strobe
	input wire logic reg_rd_i, // Read strobe
	output logic [7:0] reg_rdata_o, // Read data, next cycle
	input wire logic battery_low_i, // Comparator output
	input wire logic rssi_above_i, // Above signal_level_threshold
	input wire logic sync_match_i, // Sync or address matched
	input wire logic payload_complete_i, // payload_complete_flag pulse
	input wire logic timeout_i, // Receive timeout pulse
	output logic [2:0] chip_state_o, // Current operating state
	output logic fifo_flush_o, // Discard FIFO, one pulse
	output logic rc_cal_busy_o, // Calibration running
	output logic [7:0] carrier_low_o, // Carrier word bits 7..0
	output logic afc_low_index_enable_o, // Improved AFC routine
	output logic battery_detector_enable_o, // Detector on
	output logic [2:0] battery_threshold_trim_o // Threshold code
);
	// ==========================================================
	// Parameter checks
	if (UNIT_BASE_CYCLES < 2 || UNIT_BASE_CYCLES > 65536)
		$error("UNIT_BASE_CYCLES out of range");
	if (CAL_CYCLES < 1 || CAL_CYCLES > 65536)
		$error("CAL_CYCLES out of range");

	// ==========================================================
	// Configuration registers
	logic [7:0] frf_low, next_frf_low;
	logic afc_low, next_afc_low;
	logic bat_en, next_bat_en;
	logic [2:0] bat_trim, next_bat_trim;
	logic [1:0] idle_unit, next_idle_unit;
	logic [1:0] rx_unit, next_rx_unit;
	logic criterion, next_criterion;
	logic [1:0] exit_action, next_exit_action;
	logic [7:0] idle_count, next_idle_count;
	logic [7:0] rx_count, next_rx_count;
	logic wake_en, next_wake_en;
	logic [2:0] mode_field, next_mode_field;
	logic wr_op, abort_req;

	assign wr_op = reg_wr_i && reg_addr_i == ADDR_OPMODE;
	assign abort_req = wr_op && reg_wdata_i[BIT_WAKE_ABORT] && !reg_wdata_i[BIT_WAKE_EN];

	// Field updates; bits not named here are dropped
	always_comb
	begin
		next_frf_low = frf_low;
		next_afc_low = afc_low;
		next_bat_en = bat_en;
		next_bat_trim = bat_trim;
		next_idle_unit = idle_unit;
		next_rx_unit = rx_unit;
		next_criterion = criterion;
		next_exit_action = exit_action;
		next_idle_count = idle_count;
		next_rx_count = rx_count;
		next_wake_en = wake_en;
		next_mode_field = mode_field;
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				ADDR_OPMODE:
				begin
					next_wake_en = reg_wdata_i[BIT_WAKE_EN];
					next_mode_field = reg_wdata_i[BIT_MODE_LO +: 3];
				end
				ADDR_FRF_LOW: next_frf_low = reg_wdata_i;
				ADDR_AFC: next_afc_low = reg_wdata_i[BIT_AFC_LOW];
				ADDR_BAT:
				begin
					next_bat_en = reg_wdata_i[BIT_BAT_EN];
					next_bat_trim = reg_wdata_i[2:0];
				end
				ADDR_WAKE_CFG:
				begin
					next_idle_unit = reg_wdata_i[BIT_IDLE_UNIT +: 2];
					next_rx_unit = reg_wdata_i[BIT_RX_UNIT +: 2];
					next_criterion = reg_wdata_i[BIT_CRITERION];
					next_exit_action = reg_wdata_i[BIT_EXIT +: 2];
				end
				ADDR_IDLE_DUR: next_idle_count = reg_wdata_i;
				ADDR_RX_DUR: next_rx_count = reg_wdata_i;
				default: next_frf_low = frf_low;
			endcase
		end
	end

	// Register the configuration
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			frf_low <= RST_FRF_LOW;
			afc_low <= 1'b0;
			bat_en <= 1'b0;
			bat_trim <= RST_BAT_TRIM;
			idle_unit <= RST_IDLE_UNIT;
			rx_unit <= RST_RX_UNIT;
			criterion <= 1'b0;
			exit_action <= RST_EXIT;
			idle_count <= RST_IDLE_COUNT;
			rx_count <= RST_RX_COUNT;
			wake_en <= 1'b0;
			mode_field <= MODE_STANDBY;
		end
		else
		begin
			frf_low <= next_frf_low;
			afc_low <= next_afc_low;
			bat_en <= next_bat_en;
			bat_trim <= next_bat_trim;
			idle_unit <= next_idle_unit;
			rx_unit <= next_rx_unit;
			criterion <= next_criterion;
			exit_action <= next_exit_action;
			idle_count <= next_idle_count;
			rx_count <= next_rx_count;
			wake_en <= next_wake_en;
			mode_field <= next_mode_field;
		end
	end

	assign carrier_low_o = frf_low;
	assign afc_low_index_enable_o = afc_low;
	assign battery_detector_enable_o = bat_en;
	assign battery_threshold_trim_o = bat_trim;

	// ==========================================================
	// RC calibration
	logic cal_busy, next_cal_busy;
	logic [15:0] cal_cnt, next_cal_cnt;

	// Trigger starts a timed run; triggers while busy are ignored
	always_comb
	begin
		next_cal_busy = cal_busy;
		next_cal_cnt = cal_cnt;
		if (cal_busy)
		begin
			next_cal_cnt = cal_cnt + 16'h0001;
			if (cal_cnt == 16'(CAL_CYCLES - 1))
				next_cal_busy = 1'b0;
		end
		else if (reg_wr_i && reg_addr_i == ADDR_RC_CAL && reg_wdata_i[BIT_CAL_TRIG])
		begin
			next_cal_busy = 1'b1;
			next_cal_cnt = 16'h0000;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cal_busy <= 1'b0;
			cal_cnt <= 16'h0000;
		end
		else
		begin
			cal_busy <= next_cal_busy;
			cal_cnt <= next_cal_cnt;
		end
	end

	assign rc_cal_busy_o = cal_busy;

	// ==========================================================
	// Time unit prescaler, restarted at each phase start
	logic [15:0] base_cnt, next_base_cnt;
	logic [5:0] mid_cnt, next_mid_cnt;
	logic [5:0] long_cnt, next_long_cnt;
	logic tick_base, tick_mid, tick_long, phase_start;

	assign tick_base = base_cnt == 16'(UNIT_BASE_CYCLES - 1);
	assign tick_mid = tick_base && mid_cnt == UNIT_RATIO_LAST;
	assign tick_long = tick_mid && long_cnt == UNIT_RATIO_LAST;

	// Tick of the unit selected by a code; reserved 00 acts as base
	// Ticks come in as an argument so the caller re-evaluates on them
	function automatic logic unit_tick(input logic [1:0] code, input logic [2:0] ticks);
		case (code)
			UNIT_MID: unit_tick = ticks[1];
			UNIT_LONG: unit_tick = ticks[2];
			default: unit_tick = ticks[0];
		endcase
	endfunction : unit_tick

	always_comb
	begin
		next_base_cnt = tick_base ? 16'h0000 : base_cnt + 16'h0001;
		next_mid_cnt = tick_base ? mid_cnt + 6'h01 : mid_cnt;
		next_long_cnt = tick_mid ? long_cnt + 6'h01 : long_cnt;
		if (phase_start)
		begin
			next_base_cnt = 16'h0000;
			next_mid_cnt = 6'h00;
			next_long_cnt = 6'h00;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			base_cnt <= 16'h0000;
			mid_cnt <= 6'h00;
			long_cnt <= 6'h00;
		end
		else
		begin
			base_cnt <= next_base_cnt;
			mid_cnt <= next_mid_cnt;
			long_cnt <= next_long_cnt;
		end
	end

	// ==========================================================
	// Listen cycle sequencer
	wake_state_e state, next_state;
	logic [7:0] units_done, next_units_done;
	logic flush_pending, next_flush_pending;
	logic [2:0] stop_mode, next_stop_mode;
	logic [2:0] chip_state, next_chip_state;
	logic next_fifo_flush, fifo_flush;
	logic sel_tick, phase_end, accept, rx_event;

	assign sel_tick = unit_tick(state == L_IDLE ? idle_unit : rx_unit,
		{tick_long, tick_mid, tick_base});
	assign phase_end = sel_tick &&
		({1'b0, units_done} + 9'h001 >= {1'b0, state == L_IDLE ? idle_count : rx_count});
	assign accept = rssi_above_i && (!criterion || sync_match_i);
	assign rx_event = payload_complete_i || timeout_i;

	// Idle/receive alternation, acceptance and exit handling
	always_comb
	begin
		next_state = state;
		next_units_done = sel_tick ? units_done + 8'h01 : units_done;
		next_flush_pending = flush_pending;
		next_stop_mode = stop_mode;
		next_fifo_flush = 1'b0;
		phase_start = 1'b0;
		case (state)
			L_OFF:
				if (next_wake_en)
				begin
					next_state = L_IDLE;
					phase_start = 1'b1;
				end
			L_IDLE:
				if (phase_end)
				begin
					next_state = L_RX;
					phase_start = 1'b1;
					next_fifo_flush = flush_pending;
					next_flush_pending = 1'b0;
				end
			L_RX:
				if (accept)
				begin
					if (exit_action == EXIT_STAY_RX)
					begin
						next_state = L_STOPPED;
						next_stop_mode = MODE_RX;
					end
					else
						next_state = L_HOLD;
				end
				else if (phase_end)
				begin
					next_state = L_IDLE;
					phase_start = 1'b1;
				end
			L_HOLD:
				if (rx_event)
				begin
					if (exit_action == EXIT_RESUME)
					begin
						next_state = L_IDLE;
						phase_start = 1'b1;
						next_flush_pending = 1'b1;
					end
					else
					begin
						next_state = L_STOPPED;
						next_stop_mode = mode_field;
					end
				end
			L_STOPPED: next_state = L_STOPPED;
			default: next_state = L_OFF;
		endcase
		if (phase_start)
			next_units_done = 8'h00;
		// Abort, or disabling a stopped cycle, returns to plain operation
		if (abort_req || (state == L_STOPPED && !next_wake_en) || (state != L_OFF &&
			!wake_en && !next_wake_en))
		begin
			next_state = L_OFF;
			next_flush_pending = 1'b0;
		end
		case (next_state)
			L_IDLE: next_chip_state = MODE_SLEEP;
			L_RX, L_HOLD: next_chip_state = MODE_RX;
			L_STOPPED: next_chip_state = next_stop_mode;
			default: next_chip_state = next_mode_field;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state <= L_OFF;
			units_done <= 8'h00;
			flush_pending <= 1'b0;
			stop_mode <= MODE_STANDBY;
			chip_state <= MODE_STANDBY;
			fifo_flush <= 1'b0;
		end
		else
		begin
			state <= next_state;
			units_done <= next_units_done;
			flush_pending <= next_flush_pending;
			stop_mode <= next_stop_mode;
			chip_state <= next_chip_state;
			fifo_flush <= next_fifo_flush;
		end
	end

	assign chip_state_o = chip_state;
	assign fifo_flush_o = fifo_flush;

	// ==========================================================
	// Read path; unmapped and unused bits read zero
	logic [7:0] rdata, next_rdata;

	always_comb
	begin
		next_rdata = rdata;
		if (reg_rd_i)
		begin
			next_rdata = 8'h00;
			case (reg_addr_i)
				ADDR_OPMODE:
				begin
					next_rdata[BIT_WAKE_EN] = wake_en;
					next_rdata[BIT_MODE_LO +: 3] = chip_state;
				end
				ADDR_FRF_LOW: next_rdata = frf_low;
				ADDR_RC_CAL: next_rdata[BIT_CAL_DONE] = !cal_busy;
				ADDR_AFC: next_rdata[BIT_AFC_LOW] = afc_low;
				ADDR_BAT:
				begin
					next_rdata[BIT_BAT_LIVE] = bat_en && battery_low_i;
					next_rdata[BIT_BAT_EN] = bat_en;
					next_rdata[2:0] = bat_trim;
				end
				ADDR_WAKE_CFG:
					next_rdata = {idle_unit, rx_unit, criterion, exit_action, 1'b0};
				ADDR_IDLE_DUR: next_rdata = idle_count;
				ADDR_RX_DUR: next_rdata = rx_count;
				ADDR_REV: next_rdata = {FULL_REV, MASK_REV};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata <= 8'h00;
		else
			rdata <= next_rdata;
	end

	assign reg_rdata_o = rdata;

	// ==========================================================
	// Assertions
	property p_trig_reads_zero;
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_rd_i && reg_addr_i == ADDR_RC_CAL |=> !reg_rdata_o[BIT_CAL_TRIG] &&
			reg_rdata_o[BIT_CAL_DONE] == !$past(rc_cal_busy_o);
	endproperty
	a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger read");

	property p_cal_start;
		@(posedge clock_i) disable iff (!rst_n_i)
		!rc_cal_busy_o && reg_wr_i && reg_addr_i == ADDR_RC_CAL &&
			reg_wdata_i[BIT_CAL_TRIG] |=> rc_cal_busy_o;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("cal not started");

	property p_frf_store;
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && reg_addr_i == ADDR_FRF_LOW |=> carrier_low_o == $past(reg_wdata_i);
	endproperty
	a_frf_store: assert property (p_frf_store) else $error("carrier byte");

	property p_bat_live;
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_rd_i && reg_addr_i == ADDR_BAT |=>
			reg_rdata_o[BIT_BAT_LIVE] == ($past(battery_low_i) &&
			$past(battery_detector_enable_o));
	endproperty
	a_bat_live: assert property (p_bat_live) else $error("battery flag");

	property p_accept_stay;
		@(posedge clock_i) disable iff (!rst_n_i)
		state == L_RX && accept && exit_action == EXIT_STAY_RX && !abort_req && wake_en
			|=> state == L_STOPPED && chip_state_o == MODE_RX;
	endproperty
	a_accept_stay: assert property (p_accept_stay) else $error("exit 00");

	property p_idle_to_rx;
		@(posedge clock_i) disable iff (!rst_n_i)
		state == L_IDLE && phase_end && !abort_req && wake_en
			|=> state == L_RX && chip_state_o == MODE_RX;
	endproperty
	a_idle_to_rx: assert property (p_idle_to_rx) else $error("idle end");

	property p_resume_flush;
		@(posedge clock_i) disable iff (!rst_n_i)
		state == L_IDLE && flush_pending && phase_end && !abort_req && wake_en
			|=> fifo_flush_o ##1 !fifo_flush_o;
	endproperty
	a_resume_flush: assert property (p_resume_flush) else $error("flush");

	property p_unused_zero;
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_rd_i && reg_addr_i == ADDR_AFC |=> reg_rdata_o[7:6] == 2'h0 &&
			reg_rdata_o[4:0] == 5'h00;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bits");
endmodule : listen_rc_cal_regs

`default_nettype wire

// ---- dv/listen_host_model.sv ----
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none

module listen_host_model
	import listen_rc_cal_pkg::*;
(
	input wire logic clock_i, // Device clock
	input wire logic [7:0] reg_rdata_i, // Read data from device
	input wire logic [2:0] chip_state_i, // Device state
	output logic [6:0] reg_addr_o, // Register address
	output logic [7:0] reg_wdata_o, // Write data
	output logic reg_wr_o, // Write strobe
	output logic reg_rd_o // Read strobe
);
	// ==========================================================
	// Idle port values
	initial
	begin
		reg_addr_o = 7'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end

	// ==========================================================
	// One write access, lines scrambled after release
	task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
		@(negedge clock_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clock_i);
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask : write_reg

	// One read access, data taken the cycle after
	task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
		@(negedge clock_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clock_i);
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		@(negedge clock_i);
		d = reg_rdata_i;
	endtask : read_reg

	// Calibration requested only from standby
	task automatic start_cal();
		if (chip_state_i === MODE_STANDBY)
			write_reg(ADDR_RC_CAL, 8'h80);
	endtask : start_cal

	// Abort, enable low and new mode in one access
	task automatic leave_listen(input logic [2:0] m);
		write_reg(ADDR_OPMODE, {2'b00, 1'b1, m, 2'b00});
	endtask : leave_listen
endmodule : listen_host_model

`default_nettype wire

// ---- dv/listen_rc_cal_regs_bench.sv ----
// Self-checking bench for the listen and RC calibration registers
`timescale 1ns/1ps
`default_nettype none

module listen_rc_cal_regs_bench;
	import listen_rc_cal_pkg::*;
	localparam int UB = 4;
	localparam int CC = 4;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [6:0] addr;
	logic [7:0] wdata, rdata, got, seed, d;
	logic wr, rd, bat_low, rssi, sync, payload, tmo, flush, busy, afc, bat_en;
	logic [2:0] state, trim;
	logic [7:0] carrier;
	int bad_count = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [6:0] addrs [7] = '{ADDR_FRF_LOW, ADDR_AFC, ADDR_BAT, ADDR_WAKE_CFG,
		ADDR_IDLE_DUR, ADDR_RX_DUR, 7'h11};
	logic [2:0] modes [4] = '{MODE_SLEEP, MODE_STANDBY, MODE_SYNTH, MODE_RX};

	// ==========================================================
	// Clock and hang guard
	always #2.5 clock_i = ~clock_i;
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			finish_test();
		end
	end

	// ==========================================================
	// Design and host
	listen_rc_cal_regs #(.UNIT_BASE_CYCLES(UB), .CAL_CYCLES(CC), .FULL_REV(4'h1),
		.MASK_REV(4'h0)) listen_rc_cal_regs_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .battery_low_i(bat_low), .rssi_above_i(rssi),
		.sync_match_i(sync), .payload_complete_i(payload), .timeout_i(tmo),
		.chip_state_o(state), .fifo_flush_o(flush), .rc_cal_busy_o(busy),
		.carrier_low_o(carrier), .afc_low_index_enable_o(afc),
		.battery_detector_enable_o(bat_en), .battery_threshold_trim_o(trim));
	listen_host_model listen_host_model_inst (.clock_i(clock_i), .reg_rdata_i(rdata),
		.chip_state_i(state), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
		.reg_rd_o(rd));

	// ==========================================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	// Expected read value after a write of d
	function automatic logic [7:0] exp_read(input logic [6:0] a, input logic [7:0] v,
		input logic b);
		case (a)
			ADDR_FRF_LOW, ADDR_IDLE_DUR, ADDR_RX_DUR: return v;
			ADDR_AFC: return v & 8'h20;
			ADDR_BAT: return {3'h0, v[3] & b, v[3:0]};
			ADDR_WAKE_CFG: return v & 8'hFE;
			default: return 8'h00;
		endcase
	endfunction : exp_read

	task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask : check

	task automatic rd_check(input logic [6:0] a, input logic [7:0] e);
		listen_host_model_inst.read_reg(a, got);
		check("read data", e, got);
	endtask : rd_check

	// Bounded wait for a chip state
	task automatic wait_state(input logic [2:0] s, input int max);
		for (int n = 0; n < max && state !== s; n++)
			@(negedge clock_i);
		check("chip state", {5'h0, s}, {5'h0, state});
	endtask : wait_state

	task automatic finish_test();
		if (bad_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	// ==========================================================
	// Main sequence
	initial
	begin
		{bat_low, rssi, sync, payload, tmo} = 5'h00;
		seed = 8'h51;
		repeat (8) @(posedge clock_i);
		@(negedge clock_i);
		rst_n_i = 1'b1;
		rd_check(ADDR_FRF_LOW, RST_FRF_LOW);
		rd_check(ADDR_RC_CAL, 8'h40);
		rd_check(ADDR_AFC, 8'h00);
		rd_check(ADDR_BAT, {5'h0, RST_BAT_TRIM});
		rd_check(ADDR_WAKE_CFG, {RST_IDLE_UNIT, RST_RX_UNIT, 1'b0, RST_EXIT, 1'b0});
		rd_check(ADDR_IDLE_DUR, RST_IDLE_COUNT);
		rd_check(ADDR_RX_DUR, RST_RX_COUNT);
		rd_check(ADDR_REV, 8'h10);
		rd_check(ADDR_OPMODE, {3'h0, MODE_STANDBY, 2'h0});
		// Random writes with read-back and output checks
		for (int i = 0; i < 40; i++)
		begin
			seed = lfsr(seed);
			d = lfsr(seed);
			bat_low = d[7] ^ seed[0];
			addr_sel: begin
				listen_host_model_inst.write_reg(addrs[seed % 7], d);
				rd_check(addrs[seed % 7], exp_read(addrs[seed % 7], d, bat_low));
			end
			if (addrs[seed % 7] == ADDR_FRF_LOW)
				check("carrier", d, carrier);
			if (addrs[seed % 7] == ADDR_AFC)
				check("afc", {7'h0, d[5]}, {7'h0, afc});
			if (addrs[seed % 7] == ADDR_BAT)
				check("battery", {4'h0, d[3:0]}, {4'h0, bat_en, trim});
		end
		// Every mode code, low two bits written high
		foreach (modes[m])
		begin
			listen_host_model_inst.write_reg(ADDR_OPMODE, {3'h0, modes[m], 2'h3});
			rd_check(ADDR_OPMODE, {3'h0, modes[m], 2'h0});
		end
		listen_host_model_inst.write_reg(ADDR_OPMODE, {3'h0, MODE_STANDBY, 2'h0});
		// Calibration: done low while running, high after
		listen_host_model_inst.start_cal();
		check("busy", 8'h01, {7'h0, busy});
		rd_check(ADDR_RC_CAL, 8'h00);
		repeat (CC + 2) @(negedge clock_i);
		rd_check(ADDR_RC_CAL, 8'h40);
		check("busy", 8'h00, {7'h0, busy});
		// Listen cycle with short phases, every exit action
		listen_host_model_inst.write_reg(ADDR_IDLE_DUR, 8'h02);
		listen_host_model_inst.write_reg(ADDR_RX_DUR, 8'h02);
		for (int e = 0; e < 3; e++)
		begin
			listen_host_model_inst.write_reg(ADDR_WAKE_CFG, {UNIT_BASE, UNIT_BASE, 1'b1,
				e[1:0], 1'b0});
			listen_host_model_inst.write_reg(ADDR_OPMODE, {3'h2, MODE_STANDBY, 2'h0});
			wait_state(MODE_SLEEP, 4);
			rssi = 1'b1;
			wait_state(MODE_RX, 4 * UB);
			wait_state(MODE_SLEEP, 4 * UB);
			sync = 1'b1;
			wait_state(MODE_RX, 4 * UB);
			repeat (6 * UB) @(negedge clock_i);
			check("accepted", {5'h0, MODE_RX}, {5'h0, state});
			payload = e[0];
			tmo = e[1];
			{rssi, sync} = 2'b00;
			@(negedge clock_i);
			{payload, tmo} = 2'b00;
			if (e == 1)
				wait_state(MODE_STANDBY, 4);
			if (e == 2)
			begin
				wait_state(MODE_SLEEP, 4);
				for (int n = 0; n < 6 * UB && flush !== 1'b1; n++)
					@(negedge clock_i);
				check("flush in rx", {4'h0, 1'b1, MODE_RX}, {4'h0, flush, state});
			end
			listen_host_model_inst.leave_listen(MODE_STANDBY);
			check("aborted", {5'h0, MODE_STANDBY}, {5'h0, state});
		end
		// Mid idle unit; level-only criterion accepts without sync
		listen_host_model_inst.write_reg(ADDR_WAKE_CFG, {UNIT_MID, UNIT_BASE, 1'b0,
			EXIT_STAY_RX, 1'b0});
		rssi = 1'b1;
		listen_host_model_inst.write_reg(ADDR_OPMODE, {3'h2, MODE_STANDBY, 2'h0});
		repeat (120 * UB) @(negedge clock_i);
		check("mid idle", {5'h0, MODE_SLEEP}, {5'h0, state});
		wait_state(MODE_RX, 16 * UB);
		repeat (6 * UB) @(negedge clock_i);
		check("level accept", {5'h0, MODE_RX}, {5'h0, state});
		rssi = 1'b0;
		listen_host_model_inst.leave_listen(MODE_STANDBY);
		check("aborted", {5'h0, MODE_STANDBY}, {5'h0, state});
		finish_test();
	end
endmodule : listen_rc_cal_regs_bench

`default_nettype wire
